// ---- rtl/power_up_mode_watchdog_sequencer.sv ----
`timescale 1ns/1ns
`include "mode_seq_defs.svh"
// Operation
// - Power-up enters request state, 75 ms window
// - Trigger word in window enters normal mode
// - Window expiry enters sleep, main regulator off
// - Watchdog disable accepted only in standby
// - Both writes give standby without watchdog
// - No-watchdog standby blocks auxiliary regulator, transceiver
module power_up_mode_watchdog_sequencer
    import mode_seq_pkg::*;
#(
    parameter int WINDOW_CYCLES = `REQ_WINDOW_CYCLES  // Request window length
) (
    input  wire logic                     SYS_CLK_IN,         // System clock
    input  wire logic                     RESET_N_IN,         // Power-on reset
    input  wire logic                     TRIGGER_IN,         // Valid trigger word
    input  wire logic [`WD_SEL_W-1:0]     TRIGGER_WD_SEL_IN,  // Period in trigger
    input  wire logic                     STANDBY_REQ_IN,     // Host asks standby
    input  wire logic                     CTRL_WR_IN,         // Mode control write
    input  wire logic                     VERIFY_WR_IN,       // Verify write
    input  wire logic [`MODE_FIELD_W-1:0] WR_DATA_IN,         // Written bits 2..0
    input  wire logic                     AUX_REG_REQ_IN,     // Aux regulator ask
    input  wire logic                     XCVR_REQ_IN,        // Transceiver ask
    output logic      [2:0]               MODE_OUT,           // Current mode code
    output logic                          MAIN_REG_EN_OUT,    // Main regulator on
    output logic                          AUX_REG_EN_OUT,     // Aux regulator on
    output logic                          XCVR_EN_OUT,        // Transceiver usable
    output logic                          WD_ACTIVE_OUT,      // Watchdog running
    output logic      [`WD_SEL_W-1:0]     WD_SEL_OUT          // Watchdog period
);

    // Elaboration check: the timer needs two counts, and an int bounds the window
    if (WINDOW_CYCLES < 2 || WINDOW_CYCLES > 32'h7fffffff) begin : g_window_check
        $error("WINDOW_CYCLES out of range");
    end

    localparam int TW = $clog2(WINDOW_CYCLES + 1);  // Timer width

    mode_t         mode;        // Current mode
    logic [TW-1:0] win_cnt;     // Request window timer
    logic          disarm;      // First disable write seen
    logic          win_done;    // Window has run out

    // Expiry on the last counted cycle, so the window is exactly its length
    assign win_done = (win_cnt == TW'(WINDOW_CYCLES - 1));

    // Window timer, held at zero outside the request state
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            win_cnt <= '0;
        end else if (mode != MODE_REQUEST || TRIGGER_IN || win_done) begin
            // Cleared on the way out, so every later entry starts at zero
            win_cnt <= '0;
        end else begin
            win_cnt <= win_cnt + TW'(1);
        end
    end

    // Disable arming; a write of any other data, or leaving standby, disarms
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            disarm <= 1'b0;
        end else if (mode != MODE_STANDBY) begin
            disarm <= 1'b0;
        end else if (CTRL_WR_IN) begin
            disarm <= (WR_DATA_IN == `WD_OFF_CODE);
        // A verify without a control write in the same cycle consumes the arming, good or bad
        end else if (VERIFY_WR_IN) begin
            disarm <= 1'b0;
        end
    end

    // Mode sequencing
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            mode       <= MODE_REQUEST;
            WD_SEL_OUT <= `WD_SEL_RESET;
        end else begin
            unique case (mode)
                MODE_REQUEST: begin
                    if (TRIGGER_IN) begin
                        mode       <= MODE_NORMAL;
                        WD_SEL_OUT <= TRIGGER_WD_SEL_IN;
                    end else if (win_done) begin
                        mode <= MODE_SLEEP;
                    end
                end
                MODE_NORMAL: begin
                    // Late triggers are ignored here; only standby leaves
                    if (STANDBY_REQ_IN) begin
                        mode <= MODE_STANDBY;
                    end
                end
                MODE_STANDBY: begin
                    // Stays in standby until an armed verify arrives
                    // verify completes disable
                    if (disarm && VERIFY_WR_IN && !CTRL_WR_IN
                        && WR_DATA_IN == `WD_OFF_CODE) begin
                        mode <= MODE_STANDBY_NOWD;
                    end
                end
                // Debug standby and sleep are left only by reset
                MODE_STANDBY_NOWD: mode <= MODE_STANDBY_NOWD;
                MODE_SLEEP:        mode <= MODE_SLEEP;
            endcase
        end
    end

    // Registered outputs follow the mode one cycle later
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            MODE_OUT        <= MODE_REQUEST;
            // Main regulator stays on through reset so the host can run
            MAIN_REG_EN_OUT <= 1'b1;
            AUX_REG_EN_OUT  <= 1'b0;
            XCVR_EN_OUT     <= 1'b0;
            WD_ACTIVE_OUT   <= 1'b1;
        end else begin
            MODE_OUT        <= mode;
            MAIN_REG_EN_OUT <= (mode != MODE_SLEEP);
            AUX_REG_EN_OUT  <= AUX_REG_REQ_IN && mode != MODE_STANDBY_NOWD
                               && mode != MODE_SLEEP;
            XCVR_EN_OUT     <= XCVR_REQ_IN && mode != MODE_STANDBY_NOWD
                               && mode != MODE_SLEEP;
            WD_ACTIVE_OUT   <= (mode != MODE_STANDBY_NOWD);
        end
    end

    // Checks on the internal mode, one cycle ahead of the registered outputs
    // Window expiry must reach sleep
    a_window_expiry: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        (mode == MODE_REQUEST && win_done && !TRIGGER_IN) |=> mode == MODE_SLEEP)
        else $error("window expiry did not sleep");

    // Trigger in request takes normal and the period
    a_trigger_normal: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        (mode == MODE_REQUEST && TRIGGER_IN)
            |=> mode == MODE_NORMAL && WD_SEL_OUT == $past(TRIGGER_WD_SEL_IN))
        else $error("trigger did not enter normal");

    // No sleep before the full window
    a_window_early: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        (mode == MODE_REQUEST && win_cnt < TW'(WINDOW_CYCLES - 1)) |=> mode != MODE_SLEEP)
        else $error("sleep before window end");

    // Timer idles at zero outside request
    a_timer_restart: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        (mode != MODE_REQUEST) |-> win_cnt == '0)
        else $error("timer not cleared");

    // Watchdog-off standby is reached only from standby
    a_disable_standby: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        (mode != MODE_STANDBY && mode != MODE_STANDBY_NOWD) |=> mode != MODE_STANDBY_NOWD)
        else $error("disable outside standby");

    // Armed verify stops the watchdog
    a_disable_seq: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        (mode == MODE_STANDBY && disarm && VERIFY_WR_IN && !CTRL_WR_IN
            && WR_DATA_IN == `WD_OFF_CODE) |=> mode == MODE_STANDBY_NOWD ##1 !WD_ACTIVE_OUT)
        else $error("disable sequence ignored");

    // Aux regulator and transceiver held off
    a_aux_blocked: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        (mode == MODE_STANDBY_NOWD) |=> !AUX_REG_EN_OUT && !XCVR_EN_OUT)
        else $error("aux or transceiver enabled");

    // Sleep drops the main regulator
    a_sleep_main: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        (mode == MODE_SLEEP) |=> !MAIN_REG_EN_OUT)
        else $error("main regulator on in sleep");

    // Main regulator stays on outside sleep
    a_main_on: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        (mode != MODE_SLEEP) |=> MAIN_REG_EN_OUT)
        else $error("main regulator off outside sleep");

    // Arming is held clear outside standby
    a_arm_standby: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        (mode != MODE_STANDBY) |=> !disarm)
        else $error("disable armed outside standby");

    // Verify with nothing armed keeps standby
    a_refused_verify: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        (mode == MODE_STANDBY && VERIFY_WR_IN && !disarm) |=> mode == MODE_STANDBY)
        else $error("unarmed verify left standby");

    // Period changes only on a trigger in request
    a_sel_hold: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        (mode != MODE_REQUEST) |=> $stable(WD_SEL_OUT))
        else $error("watchdog period changed");

    // Normal is kept until standby is asked
    a_normal_hold: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        (mode == MODE_NORMAL && !STANDBY_REQ_IN) |=> mode == MODE_NORMAL)
        else $error("normal mode left unasked");

    // Sleep is left only by reset
    a_sleep_stays: assert property (
        @(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
        (mode == MODE_SLEEP) |=> mode == MODE_SLEEP)
        else $error("sleep left without reset");

endmodule

// ---- rtl/mode_seq_defs.svh ----
`ifndef MODE_SEQ_DEFS_SVH
`define MODE_SEQ_DEFS_SVH
// Request window length in milliseconds
`define REQ_WINDOW_MS      75
// Clock rate in kHz (250 MHz)
`define CLK_KHZ            250000
// Request window in clock cycles, derived from the figures above
`define REQ_WINDOW_CYCLES  (`REQ_WINDOW_MS * `CLK_KHZ)
// Mode control field value that arms or confirms the watchdog disable
`define WD_OFF_CODE        3'h3
// Width of the written mode control data field
`define MODE_FIELD_W       3
// Width of the watchdog period selector
`define WD_SEL_W           2
// Reset value of the selected watchdog period
`define WD_SEL_RESET       2'h0
`endif

// ---- rtl/mode_seq_pkg.sv ----
package mode_seq_pkg;
    // Operating modes of the sequencer
    typedef enum logic [2:0] {
        MODE_REQUEST,
        MODE_NORMAL,
        MODE_STANDBY,
        MODE_STANDBY_NOWD,
        MODE_SLEEP
    } mode_t;
endpackage

// ---- sim/host_model.sv ----
`timescale 1ns/1ns
// Host side: strobes last one cycle, a released period shows the inverse, and released data returns to 3'h4
module host_model (
    input  wire logic       clk_in,
    output logic            trig_out,
    output logic [1:0]      sel_out,
    output logic            stby_out,
    output logic            ctrl_out,
    output logic            vfy_out,
    output logic [2:0]      data_out
);
    // Idle at power-up
    initial begin
        {trig_out, stby_out, ctrl_out, vfy_out} = 4'h0;
        sel_out = 2'h0;
        data_out = 3'h4;
    end
    task automatic trig(input logic [1:0] s);
        @(posedge clk_in) #1;
        trig_out = 1'b1;
        sel_out = s;
        @(posedge clk_in) #1;
        trig_out = 1'b0;
        sel_out = ~s;
    endtask
    // Ask normal to standby
    task automatic stby();
        @(posedge clk_in) #1;
        stby_out = 1'b1;
        @(posedge clk_in) #1;
        stby_out = 1'b0;
    endtask
    task automatic wd_off(input logic [2:0] c);
        @(posedge clk_in) #1;
        ctrl_out = 1'b1;
        data_out = c;
        @(posedge clk_in) #1;
        ctrl_out = 1'b0;
        vfy_out = 1'b1;
        data_out = 3'h3;
        @(posedge clk_in) #1;
        vfy_out = 1'b0;
        data_out = 3'h4;
    endtask
endmodule

// ---- sim/power_up_mode_watchdog_sequencer_bench.sv ----
`timescale 1ns/1ns
module power_up_mode_watchdog_sequencer_bench;
    logic       clk = 1'b0;     // 250 MHz
    logic       rst_n = 1'b0;   // Sync reset
    logic       aux_req = 1'b1; // High except while request gating is checked
    logic       xcvr_req = 1'b1;
    wire        trig, stby, ctrl, vfy, main_en, aux_en, xcvr_en, wd_on;
    wire  [1:0] sel, wd_sel;
    wire  [2:0] data, mode;
    int         failures = 0;
    int         cmp_count = 0;
    always #2 clk = ~clk;
    host_model i_host_model (.clk_in(clk), .trig_out(trig), .sel_out(sel),
        .stby_out(stby), .ctrl_out(ctrl), .vfy_out(vfy), .data_out(data));
    // Short window keeps the run brief
    power_up_mode_watchdog_sequencer #(.WINDOW_CYCLES(20)) i_power_up_mode_watchdog_sequencer (
        .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .TRIGGER_IN(trig), .TRIGGER_WD_SEL_IN(sel),
        .STANDBY_REQ_IN(stby), .CTRL_WR_IN(ctrl), .VERIFY_WR_IN(vfy), .WR_DATA_IN(data),
        .AUX_REG_REQ_IN(aux_req), .XCVR_REQ_IN(xcvr_req), .MODE_OUT(mode),
        .MAIN_REG_EN_OUT(main_en), .AUX_REG_EN_OUT(aux_en), .XCVR_EN_OUT(xcvr_en),
        .WD_ACTIVE_OUT(wd_on), .WD_SEL_OUT(wd_sel));
    // Compare a code
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %b want %b", $time, got, exp);
        end
    endtask
    // Wait n edges then settle
    task automatic edges(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Reset for 4 cycles
    task automatic do_reset();
        rst_n = 1'b0;
        edges(4);
        rst_n = 1'b1;
    endtask
    // No trigger: full window, then sleep with main regulator off
    task automatic t_expiry();
        do_reset();
        edges(20);
        chk(mode, 3'h0); // still waiting at window end
        chk({2'h0, main_en}, 3'h1); // main still on
        edges(1);
        chk(mode, 3'h4); // sleep
        chk({2'h0, main_en}, 3'h0); // main off
    endtask
    // Reset out of sleep, then a mid-window reset restarts the count
    task automatic t_restart();
        do_reset();
        chk({wd_on, aux_en, main_en}, 3'h5); // reset levels
        chk({1'b0, wd_sel}, 3'h0); // period at reset
        edges(15);
        do_reset();
        edges(20);
        chk(mode, 3'h0); // timer restarted
        edges(1);
        chk(mode, 3'h4); // full window again
    endtask
    // Trigger, refused disables, then disable in standby
    task automatic t_normal_standby();
        do_reset();
        i_host_model.trig(2'h2);
        edges(1);
        chk(mode, 3'h1); // normal
        chk({1'b0, wd_sel}, 3'h2); // period taken
        edges(25);
        chk(mode, 3'h1); // timer stopped
        i_host_model.trig(2'h1);
        edges(1);
        chk({1'b0, wd_sel}, 3'h2); // late trigger ignored
        i_host_model.wd_off(3'h3);
        edges(1);
        chk({mode[1:0], wd_on}, 3'h3); // refused in normal
        i_host_model.stby();
        edges(1);
        chk(mode, 3'h2); // standby reached
        chk({aux_en, xcvr_en, wd_on}, 3'h7); // standby still guarded
        aux_req = 1'b0;
        edges(1);
        chk({aux_en, xcvr_en, wd_on}, 3'h3); // aux follows its request
        aux_req = 1'b1;
        i_host_model.wd_off(3'h5);
        edges(1);
        chk({mode[1:0], wd_on}, 3'h5); // wrong control data refused
        i_host_model.wd_off(3'h3);
        edges(1);
        chk(mode, 3'h3); // no-watchdog standby
        chk({wd_on, aux_en, xcvr_en}, 3'h0); // aux and bus blocked
    endtask
    // Print counts and verdict
    task automatic complete_run();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Tests take ~120 cycles; allow about seventeen times that
    initial begin
        #8000;
        failures++;
        complete_run();
    end
    initial begin
        t_expiry();
        t_restart();
        t_normal_standby();
        complete_run();
    end
endmodule
